// File: pkg/marc_pkg.sv
// constants, state type and helpers for the modem rate converter
package marc_pkg;

    localparam int CORE_HZ = 100_000_000;
    localparam int BIT_HZ = 1200;
    localparam int RX_MAX_HZ = 1219;
    // rounded down: the internal bit clock stays well inside the 0.01% window
    localparam int TX_BIT_CYC = CORE_HZ / BIT_HZ;
    // rounded up: the restored stream can never beat its ceiling
    localparam int RX_BIT_CYC = (CORE_HZ + RX_MAX_HZ - 1) / RX_MAX_HZ;
    localparam int CNT_W = 17;
    localparam int SCR_LEN = 17;
    localparam int SCR_TAP = 14;
    localparam logic [3:0] DATA_MIN = 4'h5;
    localparam logic [3:0] FRAME_EXTRA = 4'h2;
    localparam logic [4:0] BRK_EXTRA = 5'h3;
    localparam logic [1:0] SYNC_IDLE = 2'h3;

    typedef enum logic [3:0] {
        SER_IDLE = 4'h1,
        SER_DATA = 4'h2,
        SER_STOP = 4'h4,
        SER_BREAK = 4'h8
    } marc_ser_t;

    // data bits per character from the length setting
    function automatic logic [3:0] marc_nbits(input logic [1:0] len);
        marc_nbits = DATA_MIN + {2'h0, len};
    endfunction

    // least break length in bits, 2*N+3 with N counting start and stop
    function automatic logic [4:0] marc_brk_len(input logic [1:0] len);
        logic [3:0] n;
        n = marc_nbits(len) + FRAME_EXTRA;
        marc_brk_len = {n, 1'b0} + BRK_EXTRA;
    endfunction

endpackage

// File: verilog/marc_rate_conv.sv
// modem serial data path: rate converters, scrambler pair, bit clocks
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Function
// (RULE1) terminal sends async data 1200, +1.0%/-2.5%
// (RULE2) transmit stream leaves at 1200 within 0.01%
// (RULE3) converted data scrambled; scrambler bypass setting
// (RULE4) fsk mode bypasses converter and scrambler
// (RULE5) one-character break stretched to 2N+3 bits
// (RULE6) receive: descrambler first, then receive converter
// (RULE7) restore deleted stops, intra-character rate <=1219
// (RULE8) long receive break passed without stop bits
// (RULE9) synchronous operation only at 1200, clock-locked
// (RULE10) terminal holds data at transmit clock rise
// (RULE11) internal mode makes 1200 Hz transmit clock
// (RULE12) slave mode uses receive clock for transmit
// (RULE13) receive output updates on receive clock fall
// (RULE14) synchronous mode bypasses transmit rate converter
// (RULE15) character length from a processor setting
////////////////////////////////////////////////////////////////////////////////
module marc_rate_conv #(
    parameter int TX_BIT_CYC_P = marc_pkg::TX_BIT_CYC,
    parameter int RX_BIT_CYC_P = marc_pkg::RX_BIT_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic rx_bit_clock,
    input wire logic sync_mode,
    input wire logic fsk_mode,
    input wire logic scram_bypass,
    input wire logic clk_slave,
    input wire logic [1:0] char_len,
    input wire logic tx_term_data,
    output logic tx_bit_clock,
    output logic tx_mod_data,
    output logic tx_mod_tick,
    input wire logic rx_demod_data,
    output logic rx_term_data
);
    import marc_pkg::*;

    logic [1:0] txd_sync_q;
    logic [1:0] rxc_sync_q;
    logic [1:0] tog_sync_q;
    logic [1:0] fsk_rx_sync_q;
    logic rxc_prev_q;
    logic tog_prev_q;
    logic tx_in;
    logic [3:0] nbits;
    logic ltog_q;

    assign tx_in = txd_sync_q[1];
    assign nbits = marc_nbits(char_len); // [RULE15]

    always_ff @(posedge core_clk) begin
        if (reset) begin
            txd_sync_q <= SYNC_IDLE;
            rxc_sync_q <= 2'h0;
            tog_sync_q <= 2'h0;
            fsk_rx_sync_q <= SYNC_IDLE;
            rxc_prev_q <= 1'b0;
            tog_prev_q <= 1'b0;
        end else begin
            txd_sync_q <= {txd_sync_q[0], tx_term_data};
            rxc_sync_q <= {rxc_sync_q[0], rx_bit_clock};
            tog_sync_q <= {tog_sync_q[0], ltog_q};
            fsk_rx_sync_q <= {fsk_rx_sync_q[0], rx_demod_data};
            rxc_prev_q <= rxc_sync_q[1];
            tog_prev_q <= tog_sync_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit bit clock
    logic [CNT_W-1:0] tx_div_q;
    logic tx_clk_q;
    logic tx_tick;
    logic div_end;

    assign div_end = (tx_div_q == CNT_W'(TX_BIT_CYC_P - 1));
    assign tx_tick = clk_slave ? (rxc_sync_q[1] & ~rxc_prev_q) : div_end; // [RULE12] [RULE2]
    assign tx_bit_clock = tx_clk_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_div_q <= '0;
            tx_clk_q <= 1'b0;
        end else begin
            tx_div_q <= div_end ? '0 : tx_div_q + 1'b1; // [RULE11]
            if (clk_slave) begin
                tx_clk_q <= rxc_sync_q[1]; // [RULE12]
            end else begin
                tx_clk_q <= (tx_div_q < CNT_W'(TX_BIT_CYC_P / 2)); // [RULE11]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // asynchronous character capture from the terminal
    logic in_busy_q;
    logic in_wait_q;
    logic brk_pend_q;
    logic hold_v_q;
    logic [CNT_W-1:0] in_cnt_q;
    logic [3:0] in_idx_q;
    logic [7:0] in_sh_q;
    logic [7:0] hold_q;
    logic tx_take;
    logic brk_take;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            in_busy_q <= 1'b0;
            in_wait_q <= 1'b0;
            brk_pend_q <= 1'b0;
            hold_v_q <= 1'b0;
            in_cnt_q <= '0;
            in_idx_q <= 4'h0;
            in_sh_q <= 8'h00;
            hold_q <= 8'h00;
        end else begin
            // clears sit first so a same-cycle set wins
            if (tx_take) hold_v_q <= 1'b0;
            if (brk_take) brk_pend_q <= 1'b0;
            if (!in_busy_q) begin
                if (tx_in) in_wait_q <= 1'b0;
                if (!in_wait_q && !tx_in && !sync_mode && !fsk_mode) begin
                    in_busy_q <= 1'b1;
                    in_cnt_q <= CNT_W'(TX_BIT_CYC_P / 2);
                    in_idx_q <= 4'h0;
                    in_sh_q <= 8'h00;
                end
            end else if (in_cnt_q == CNT_W'(TX_BIT_CYC_P - 1)) begin
                // mid-bit sampling tolerates the terminal's rate error
                in_cnt_q <= '0; // [RULE1]
                if (in_idx_q == 4'h0 && tx_in) begin
                    in_busy_q <= 1'b0;
                end else if (in_idx_q <= nbits) begin
                    if (in_idx_q != 4'h0) in_sh_q <= {tx_in, in_sh_q[7:1]};
                    in_idx_q <= in_idx_q + 4'h1;
                end else begin
                    in_busy_q <= 1'b0;
                    in_wait_q <= ~tx_in;
                    if (!tx_in && in_sh_q == 8'h00) begin
                        brk_pend_q <= 1'b1; // [RULE5]
                    end else begin
                        hold_q <= in_sh_q >> (4'h8 - nbits);
                        hold_v_q <= 1'b1;
                    end
                end
            end else begin
                in_cnt_q <= in_cnt_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit converter: one character in flight, one held
    marc_ser_t tx_st_q;
    logic [7:0] tx_sh_q;
    logic [3:0] tx_idx_q;
    logic [4:0] brk_cnt_q;
    logic tx_raw;

    always_comb begin
        tx_raw = 1'b1;
        tx_take = 1'b0;
        brk_take = 1'b0;
        if (sync_mode) begin
            tx_raw = tx_in; // [RULE14] [RULE9] [RULE10]
        end else begin
            case (tx_st_q)
                SER_IDLE: begin
                    if (brk_pend_q) begin
                        tx_raw = 1'b0;
                        brk_take = tx_tick;
                    end else if (hold_v_q) begin
                        tx_raw = 1'b0;
                        tx_take = tx_tick;
                    end
                end
                SER_DATA: tx_raw = tx_sh_q[0];
                SER_STOP: begin
                    // input running fast: drop this stop, start the next char
                    if (hold_v_q && in_busy_q) begin
                        tx_raw = 1'b0; // [RULE2]
                        tx_take = tx_tick;
                    end
                end
                SER_BREAK: tx_raw = 1'b0;
                default: tx_raw = 1'b1;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_st_q <= SER_IDLE;
            tx_sh_q <= 8'h00;
            tx_idx_q <= 4'h0;
            brk_cnt_q <= 5'h00;
        end else if (sync_mode || fsk_mode) begin
            tx_st_q <= SER_IDLE; // [RULE4] [RULE14]
        end else if (tx_tick) begin
            case (tx_st_q)
                SER_IDLE: begin
                    if (brk_take) begin
                        tx_st_q <= SER_BREAK;
                        brk_cnt_q <= marc_brk_len(char_len) - 5'h01; // [RULE5]
                    end else if (tx_take) begin
                        tx_st_q <= SER_DATA;
                        tx_sh_q <= hold_q;
                        tx_idx_q <= 4'h0;
                    end
                end
                SER_DATA: begin
                    tx_sh_q <= {1'b1, tx_sh_q[7:1]};
                    tx_idx_q <= tx_idx_q + 4'h1;
                    if (tx_idx_q == nbits - 4'h1) tx_st_q <= SER_STOP;
                end
                SER_STOP: begin
                    if (tx_take) begin
                        tx_st_q <= SER_DATA;
                        tx_sh_q <= hold_q;
                        tx_idx_q <= 4'h0;
                    end else begin
                        tx_st_q <= SER_IDLE;
                    end
                end
                SER_BREAK: begin
                    if (brk_cnt_q != 5'h00) begin
                        brk_cnt_q <= brk_cnt_q - 5'h01; // [RULE5]
                    end else if (tx_in) begin
                        tx_st_q <= SER_IDLE;
                    end
                end
                default: tx_st_q <= SER_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // scrambler, x^-14 + x^-17 self-synchronising
    logic [SCR_LEN-1:0] tx_scr_q;
    logic tx_scr_bit;
    logic tx_mod_data_q;
    logic tx_mod_tick_q;

    assign tx_scr_bit = tx_raw ^ tx_scr_q[SCR_TAP-1] ^ tx_scr_q[SCR_LEN-1];
    assign tx_mod_data = tx_mod_data_q;
    assign tx_mod_tick = tx_mod_tick_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_scr_q <= '0;
            tx_mod_data_q <= 1'b1;
            tx_mod_tick_q <= 1'b0;
        end else begin
            tx_mod_tick_q <= tx_tick & ~fsk_mode;
            if (fsk_mode) begin
                tx_mod_data_q <= tx_in; // [RULE4]
            end else if (tx_tick) begin
                if (scram_bypass) begin
                    tx_mod_data_q <= tx_raw; // [RULE3]
                end else begin
                    tx_mod_data_q <= tx_scr_bit; // [RULE3]
                    tx_scr_q <= {tx_scr_q[SCR_LEN-2:0], tx_scr_bit};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive bit clock domain: descrambler
    logic [1:0] lrst_q;
    logic [1:0] lbyp_q;
    logic [SCR_LEN-1:0] dsc_q;
    logic lbit_q;
    logic rx_sync_out_q;

    always_ff @(posedge rx_bit_clock) begin
        lrst_q <= {lrst_q[0], reset};
    end

    always_ff @(posedge rx_bit_clock) begin
        if (lrst_q[1]) begin
            lbyp_q <= 2'h0;
            dsc_q <= '0;
            lbit_q <= 1'b1;
            ltog_q <= 1'b0;
        end else begin
            lbyp_q <= {lbyp_q[0], scram_bypass};
            dsc_q <= {dsc_q[SCR_LEN-2:0], rx_demod_data};
            if (lbyp_q[1]) begin
                lbit_q <= rx_demod_data;
            end else begin
                lbit_q <= rx_demod_data ^ dsc_q[SCR_TAP-1] ^ dsc_q[SCR_LEN-1]; // [RULE6]
            end
            ltog_q <= ~ltog_q;
        end
    end

    always_ff @(negedge rx_bit_clock) begin
        if (lrst_q[1]) begin
            rx_sync_out_q <= 1'b1;
        end else begin
            rx_sync_out_q <= lbit_q; // [RULE13]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive converter: reframe, then replay a little faster
    logic rx_bit_ev;
    logic async_rx;
    logic fr_act_q;
    logic rx_brk_q;
    logic rq_v_q;
    logic [3:0] fr_idx_q;
    logic [7:0] fr_sh_q;
    logic [7:0] rq_q;
    logic rs_take;

    // lbit_q is steady for a whole bit, long after the toggle settles
    assign rx_bit_ev = tog_sync_q[1] ^ tog_prev_q;
    assign async_rx = ~sync_mode & ~fsk_mode;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fr_act_q <= 1'b0;
            rx_brk_q <= 1'b0;
            rq_v_q <= 1'b0;
            fr_idx_q <= 4'h0;
            fr_sh_q <= 8'h00;
            rq_q <= 8'h00;
        end else begin
            if (rs_take) rq_v_q <= 1'b0;
            if (rx_bit_ev && async_rx) begin
                if (rx_brk_q) begin
                    if (lbit_q) begin
                        rx_brk_q <= 1'b0; // [RULE8]
                        fr_act_q <= 1'b0;
                    end
                end else if (!fr_act_q) begin
                    fr_act_q <= ~lbit_q;
                    fr_idx_q <= 4'h0;
                    fr_sh_q <= 8'h00;
                end else if (fr_idx_q != nbits) begin
                    fr_sh_q <= {lbit_q, fr_sh_q[7:1]};
                    fr_idx_q <= fr_idx_q + 4'h1;
                end else if (!lbit_q && fr_sh_q == 8'h00) begin
                    rx_brk_q <= 1'b1; // [RULE8]
                end else begin
                    // low stop slot: stop was deleted and this is the next start
                    rq_q <= fr_sh_q >> (4'h8 - nbits);
                    rq_v_q <= 1'b1; // [RULE7]
                    fr_act_q <= ~lbit_q;
                    fr_idx_q <= 4'h0;
                    fr_sh_q <= 8'h00;
                end
            end
        end
    end

    logic [CNT_W-1:0] rs_cnt_q;
    logic rs_tick;
    marc_ser_t rs_st_q;
    logic [7:0] rs_sh_q;
    logic [3:0] rs_idx_q;
    logic rs_out_q;

    assign rs_tick = (rs_cnt_q == CNT_W'(RX_BIT_CYC_P - 1));
    assign rs_take = rs_tick && rs_st_q == SER_IDLE && rq_v_q && !rx_brk_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rs_cnt_q <= '0;
            rs_st_q <= SER_IDLE;
            rs_sh_q <= 8'h00;
            rs_idx_q <= 4'h0;
            rs_out_q <= 1'b1;
        end else begin
            rs_cnt_q <= rs_tick ? '0 : rs_cnt_q + 1'b1; // [RULE7]
            if (rs_tick) begin
                case (rs_st_q)
                    SER_IDLE: begin
                        if (rx_brk_q) begin
                            rs_out_q <= 1'b0;
                            rs_st_q <= SER_BREAK;
                        end else if (rq_v_q) begin
                            rs_out_q <= 1'b0;
                            rs_sh_q <= rq_q;
                            rs_idx_q <= 4'h0;
                            rs_st_q <= SER_DATA;
                        end else begin
                            rs_out_q <= 1'b1;
                        end
                    end
                    SER_DATA: begin
                        rs_out_q <= rs_sh_q[0];
                        rs_sh_q <= {1'b1, rs_sh_q[7:1]};
                        rs_idx_q <= rs_idx_q + 4'h1;
                        if (rs_idx_q == nbits - 4'h1) rs_st_q <= SER_STOP;
                    end
                    SER_STOP: begin
                        rs_out_q <= 1'b1; // [RULE7]
                        rs_st_q <= SER_IDLE;
                    end
                    SER_BREAK: begin
                        rs_out_q <= rx_brk_q ? 1'b0 : 1'b1; // [RULE8]
                        if (!rx_brk_q) rs_st_q <= SER_IDLE;
                    end
                    default: begin
                        rs_out_q <= 1'b1;
                        rs_st_q <= SER_IDLE;
                    end
                endcase
            end
        end
    end

    // sync mode takes the negedge flop straight; fsk skips both stages
    assign rx_term_data = sync_mode ? rx_sync_out_q
                                    : (fsk_mode ? fsk_rx_sync_q[1] : rs_out_q); // [RULE9]

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [CNT_W-1:0] gap_q;

    always_ff @(posedge core_clk) begin
        if (reset || tx_tick) begin
            gap_q <= '0;
        end else begin
            gap_q <= gap_q + 1'b1;
        end
    end

    AST_TX_RATE: assert property (@(posedge core_clk) disable iff (reset) // [RULE2]
        !clk_slave |-> gap_q <= CNT_W'(TX_BIT_CYC_P - 1))
        else $error("tx period too long");
    AST_SCR_ON: assert property (@(posedge core_clk) disable iff (reset) // [RULE3]
        tx_tick && !scram_bypass && !fsk_mode |=> tx_mod_data_q == $past(tx_scr_bit))
        else $error("scrambled bit not sent");
    AST_SCR_OFF: assert property (@(posedge core_clk) disable iff (reset) // [RULE3]
        tx_tick && scram_bypass && !fsk_mode |=> tx_mod_data_q == $past(tx_raw))
        else $error("plain bit not sent");
    AST_FSK_TX: assert property (@(posedge core_clk) disable iff (reset) // [RULE4]
        fsk_mode ##1 fsk_mode |-> tx_mod_data_q == $past(tx_in) && tx_st_q == SER_IDLE)
        else $error("fsk path not bypassed");
    AST_BRK_LOAD: assert property (@(posedge core_clk) disable iff (reset) // [RULE5]
        tx_st_q != SER_BREAK ##1 tx_st_q == SER_BREAK
        |-> brk_cnt_q == marc_brk_len(char_len) - 5'h01)
        else $error("break length not loaded");
    AST_BRK_END: assert property (@(posedge core_clk) disable iff (reset) // [RULE5]
        tx_st_q == SER_BREAK && !sync_mode && !fsk_mode ##1 tx_st_q != SER_BREAK
        |-> $past(brk_cnt_q) == 5'h00 && $past(tx_in))
        else $error("break ended early");
    AST_RX_PACE: assert property (@(posedge core_clk) disable iff (reset) // [RULE7]
        !rs_tick |=> $stable(rs_out_q))
        else $error("rx output moved mid-slot");
    AST_RX_BRK: assert property (@(posedge core_clk) disable iff (reset) // [RULE8]
        rs_st_q == SER_BREAK && rx_brk_q && rs_tick |=> !rs_out_q)
        else $error("stop inserted into break");
    AST_RX_FALL: assert property (@(posedge rx_bit_clock) disable iff (lrst_q[1]) // [RULE13]
        ##1 rx_sync_out_q == lbit_q)
        else $error("rx data not moved on fall");
    AST_SLAVE_CLK: assert property (@(posedge core_clk) disable iff (reset) // [RULE12]
        clk_slave ##1 clk_slave |-> tx_clk_q == $past(rxc_sync_q[1]))
        else $error("slave tx clock wrong");
    AST_SYNC_BYP: assert property (@(posedge core_clk) disable iff (reset) // [RULE14]
        sync_mode ##1 sync_mode |-> tx_st_q == SER_IDLE)
        else $error("converter active in sync mode");

    COV_TX_BREAK: cover property (@(posedge core_clk) disable iff (reset)
        tx_st_q == SER_BREAK);
    COV_STOP_DROP: cover property (@(posedge core_clk) disable iff (reset)
        tx_st_q == SER_STOP && tx_take);
    COV_RX_BREAK: cover property (@(posedge core_clk) disable iff (reset)
        rs_st_q == SER_BREAK);
    COV_SYNC_TICK: cover property (@(posedge core_clk) disable iff (reset)
        sync_mode && tx_tick);

endmodule // marc_rate_conv

// File: verif/marc_term_model.sv
// terminal side model: drives the transmit serial pin
`timescale 1ns/100ps
module marc_term_model (
    input wire logic core_clk,
    input wire logic tx_bit_clock,
    output logic tx_term_data
);
    initial tx_term_data = 1'b1;

    task send_async(input logic [7:0] d, input int n, input int per);
        for (int i = -1; i <= n; i++) begin
            @(posedge core_clk);
            tx_term_data <= (i < 0) ? 1'b0 : ((i == n) ? 1'b1 : d[i[2:0]]);
            repeat (per - 1) @(posedge core_clk);
        end
    endtask

    task hold_low(input int cyc);
        @(posedge core_clk);
        tx_term_data <= 1'b0;
        repeat (cyc) @(posedge core_clk);
        tx_term_data <= 1'b1;
    endtask

    // change on the fall so the bit is settled at the rise
    task send_sync(input logic [9:0] f);
        for (int i = 0; i < 10; i++) begin
            @(negedge tx_bit_clock);
            @(posedge core_clk);
            tx_term_data <= f[i];
        end
    endtask
endmodule // marc_term_model

// File: verif/testbench.sv
// self-checking bench for the modem rate converter
`timescale 1ns/100ps
module testbench;
    import marc_pkg::*;
    localparam int TXC = 100;
    localparam int RXC = 12;
    localparam int BRK = 2 * (8 + 2) + 3;
    logic core_clk = 1'b0;
    logic rx_bit_clock = 1'b0;
    logic reset = 1'b1;
    logic sync_mode = 1'b0;
    logic fsk_mode = 1'b0;
    logic scram_bypass = 1'b1;
    logic clk_slave = 1'b0;
    logic [1:0] char_len = 2'h3;
    logic rx_demod_data = 1'b1;
    logic tx_term_data, tx_bit_clock, tx_mod_data, tx_mod_tick, rx_term_data;
    logic [1:0] tk = 2'h0;
    logic [16:0] hist = 17'h0;
    logic bit_ok = 1'b0;
    logic bit_raw, bit_desc;
    int miscompares = 0;
    int n_tests = 0;

    initial forever #5 core_clk = ~core_clk;
    initial begin
        #3.7;
        forever #62.5 rx_bit_clock = ~rx_bit_clock;
    end

    marc_rate_conv #(.TX_BIT_CYC_P(TXC), .RX_BIT_CYC_P(RXC)) marc_rate_conv_i (
        .core_clk(core_clk), .reset(reset), .rx_bit_clock(rx_bit_clock),
        .sync_mode(sync_mode), .fsk_mode(fsk_mode), .scram_bypass(scram_bypass),
        .clk_slave(clk_slave), .char_len(char_len), .tx_term_data(tx_term_data),
        .tx_bit_clock(tx_bit_clock), .tx_mod_data(tx_mod_data), .tx_mod_tick(tx_mod_tick),
        .rx_demod_data(rx_demod_data), .rx_term_data(rx_term_data));
    marc_term_model marc_term_model_i (.core_clk(core_clk), .tx_bit_clock(tx_bit_clock),
        .tx_term_data(tx_term_data));

    always @(posedge core_clk) begin
        tk <= {tk[0], tx_mod_tick};
        bit_ok <= tk[1];
        if (tk[1]) begin
            bit_raw <= tx_mod_data;
            bit_desc <= tx_mod_data ^ hist[13] ^ hist[16];
            hist <= {hist[15:0], tx_mod_data};
        end
    end
////////////////////////////////////////////////////////////
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task wrap_up;
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task set_mode(input logic s, f, b, input logic [1:0] c);
        @(posedge core_clk);
        sync_mode <= s;
        fsk_mode <= f;
        scram_bypass <= b;
        char_len <= c;
        cyc(4);
    endtask

    task next_bit(output logic b);
        for (int i = 0; i < 300; i++) begin
            cyc(1);
            if (bit_ok === 1'b1) break;
        end
        b = (scram_bypass === 1'b0) ? bit_desc : bit_raw;
    endtask

    task tx_char(input logic [7:0] d, input int n);
        logic b;
        int i;
        b = 1'b1;
        for (i = 0; i < 200 && b !== 1'b0; i++) next_bit(b);
        chk("tx_start", 8'h00, {7'h0, b});
        for (i = 0; i < n; i++) begin
            next_bit(b);
            chk("tx_data", {7'h0, d[i]}, {7'h0, b});
        end
        next_bit(b);
        chk("tx_stop", 8'h01, {7'h0, b});
    endtask

    task rx_char(input logic [7:0] d);
        int i;
        for (i = 0; i < 3000 && rx_term_data !== 1'b0; i++) cyc(1);
        cyc(RXC / 2);
        chk("rx_start", 8'h00, {7'h0, rx_term_data});
        for (i = 0; i < 9; i++) begin
            cyc(RXC);
            chk("rx_bit", (i < 8) ? {7'h0, d[i]} : 8'h01, {7'h0, rx_term_data});
        end
    endtask

    task rx_drive(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge rx_bit_clock);
            rx_demod_data <= v[i];
        end
    endtask
////////////////////////////////////////////////////////////
    task t_clock;
        int i, hi, lo;
        hi = 0;
        lo = 0;
        for (i = 0; i < 300 && tx_bit_clock !== 1'b0; i++) cyc(1);
        for (i = 0; i < 300 && tx_bit_clock !== 1'b1; i++) cyc(1);
        for (; tx_bit_clock === 1'b1 && hi < 300; hi++) cyc(1);
        for (; tx_bit_clock === 1'b0 && lo < 300; lo++) cyc(1);
        chk("clk_high", 8'h32, hi[7:0]);
        chk("clk_period", 8'h64, 8'(hi + lo));
        @(posedge core_clk);
        clk_slave <= 1'b1;
        cyc(30);
        hi = 0;
        for (i = 0; i < 100; i++) begin
            cyc(1);
            hi += (tx_mod_tick === 1'b1);
        end
        chk("slave_ticks", 8'h08, hi[7:0]);
        @(posedge core_clk);
        clk_slave <= 1'b0;
        cyc(250);
    endtask

    task t_async;
        int c, i;
        logic b;
        logic [7:0] d;
        for (c = 0; c < 4; c++) begin
            set_mode(1'b0, 1'b0, c[0], c[1:0]);
            d = {c[1:0], 4'h6, c[1:0]};
            for (i = 0; i < 20; i++) next_bit(b);
            fork
                marc_term_model_i.send_async(d, 5 + c, TXC - 1 + c);
                tx_char(d, 5 + c);
            join
        end
        set_mode(1'b0, 1'b0, 1'b1, 2'h3);
        fork
            for (i = 0; i < 4; i++) marc_term_model_i.send_async(8'h0F << i, 8, TXC - 1);
            for (c = 0; c < 4; c++) tx_char(8'h0F << c, 8);
        join
    endtask

    task t_break;
        int n;
        logic b;
        b = 1'b1;
        fork
            marc_term_model_i.hold_low(10 * TXC);
            begin
                for (n = 0; n < 50 && b !== 1'b0; n++) next_bit(b);
                for (n = 0; n < 80 && b === 1'b0; n++) next_bit(b);
            end
        join
        chk("tx_break", 8'h01, {7'h0, n >= BRK});
        cyc(5 * TXC);
    endtask

    task t_sync;
        set_mode(1'b1, 1'b0, 1'b1, 2'h3);
        fork
            marc_term_model_i.send_sync({1'b1, 8'hC3, 1'b0});
            tx_char(8'hC3, 8);
        join
    endtask

    task t_fsk;
        set_mode(1'b0, 1'b1, 1'b1, 2'h3);
        @(negedge rx_bit_clock);
        rx_demod_data <= 1'b0;
        fork
            marc_term_model_i.hold_low(40);
            begin
                cyc(25);
                chk("fsk_out", 8'h00, {6'h0, tx_mod_data, tx_mod_tick});
                chk("fsk_rx", 8'h00, {7'h0, rx_term_data});
            end
        join
        cyc(20);
        chk("fsk_out", 8'h02, {6'h0, tx_mod_data, tx_mod_tick});
        rx_demod_data <= 1'b1;
    endtask

    task t_rx;
        int n;
        set_mode(1'b0, 1'b0, 1'b1, 2'h3);
        cyc(100);
        fork
            rx_drive({2'b11, 8'h5C, 1'b0, 8'hA3, 1'b0, 4'hF}, 24);
            begin
                rx_char(8'hA3);
                rx_char(8'h5C);
            end
        join
        cyc(100);
        fork
            rx_drive({2'b11, 28'h0, 2'b11}, 32);
            begin
                for (n = 0; n < 3000 && rx_term_data !== 1'b0; n++) cyc(1);
                for (n = 0; n < 1000 && rx_term_data === 1'b0; n++) cyc(1);
            end
        join
        chk("rx_break", 8'h01, {7'h0, n >= 150 && n < 1000});
    endtask

    task t_rx_sync;
        logic [16:0] s;
        logic p, prev, line;
        s = 17'h0;
        prev = 1'b1;
        set_mode(1'b1, 1'b0, 1'b0, 2'h3);
        for (int i = 0; i < 40; i++) begin
            p = (i < 18) ? 1'b1 : i[0] ^ i[2];
            line = p ^ s[13] ^ s[16];
            s = {s[15:0], line};
            @(negedge rx_bit_clock);
            rx_demod_data <= line;
            #1;
            if (i >= 19) chk("rx_sync", {7'h0, prev}, {7'h0, rx_term_data});
            @(posedge rx_bit_clock);
            #1;
            if (i >= 19) chk("rx_hold", {7'h0, prev}, {7'h0, rx_term_data});
            prev = p;
        end
    endtask
////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        wrap_up;
    end

    initial begin
        // link reset needs three rx clock edges
        cyc(40);
        chk("reset_outs", 8'h09, {4'h0, tx_mod_data, tx_mod_tick, tx_bit_clock, rx_term_data});
        @(posedge core_clk);
        reset <= 1'b0;
        t_clock;
        t_async;
        t_break;
        t_sync;
        t_fsk;
        t_rx;
        t_rx_sync;
        wrap_up;
    end
endmodule // testbench
